// [hw/psc_pin_state.sv]
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Bus request and standby entry together: standby wins.
// - Standby with port high-impedance bit set floats port pins and clock output.
// - After power-on reset top four address lines become input ports.
// - Keep state: input pins float, output pins hold the level of the last normal-mode cycle.
// - Row strobe high on on-chip access, low only in row-active or refresh.
// - Column strobes high on on-chip access, low only during refresh.
// - On-chip access: selects, strobes high, address-hold low, address driven, data floats.
// - Bus released: grant low, bus lines float, bus request still sampled.
// - Standby floats bus, selects and strobes; clock output high unless floated.
module psc_pin_state (
  input  wire logic                       sys_clk_i,      // 20 MHz clock
  input  wire logic                       resetn_i,       // Async reset, active low
  input  wire logic                       clk_en_i,       // Clock enable
  input  wire logic                       power_on_i,     // Reset cause is power-on
  input  wire logic                       manual_reset_in_i, // Manual reset pin, active low
  input  wire logic                       bus_request_in_i,  // Bus request pin, active low
  input  wire psc_pkg::psc_ctrl_t         ctrl_i,         // Core requests
  input  wire logic                       clk_int_i,      // Internal clock level for pin
  input  wire logic [psc_pkg::DATA_W-1:0] port_out_i,     // General port output data
  input  wire logic [psc_pkg::DATA_W-1:0] port_dir_i,     // General port direction, 1 out
  output logic [psc_pkg::DATA_W-1:0]      port_o,         // General port pin data
  output logic [psc_pkg::DATA_W-1:0]      port_oe_o,      // General port enables
  output logic                            clock_output_o, // Clock output pin
  output logic                            clock_output_oe_o, // Clock output enable
  output logic                            bus_grant_n_o,  // Bus grant, active low
  output logic                            bus_grant_oe_o, // Bus grant enable
  output logic [psc_pkg::ADDR_W-1:0]      addr_o,         // Address pins
  output logic [psc_pkg::ADDR_W-1:0]      addr_oe_o,      // Address enables
  output logic                            data_oe_o,      // Data bus enable
  output psc_pkg::psc_busctl_t            busctl_o,       // Bus control levels
  output logic                            busctl_oe_o,    // Bus control enable
  output psc_pkg::psc_mode_t              mode_o          // Current pin mode
);
  import psc_pkg::*;

  localparam psc_busctl_t BUSCTL_IDLE = '{cs_n: '1, row_strobe_n: 1'b1,
    col_strobe_n: '1, rd_wr: 1'b1, rd_n: 1'b1, wr_strobe_n: '1, address_hold_n: 1'b0};

  logic [1:0]        manual_reset_in_sync_r, bus_request_in_sync_r;
  logic [1:0]        manual_reset_in_sync_nxt, bus_request_in_sync_nxt;
  psc_mode_t         mode_r, mode_nxt;
  logic              addr_port_r, addr_port_nxt;
  logic              hiz_r, hiz_nxt;
  logic [DATA_W-1:0] keep_val_r, keep_val_nxt;
  logic [DATA_W-1:0] keep_dir_r, keep_dir_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  psc_busctl_t       busctl_r, busctl_nxt;
  logic              bus_request_in_act, manual_reset_in_act, in_sby, in_rel;

  // Pin synchronisers
  always_comb begin
    manual_reset_in_sync_nxt = {manual_reset_in_sync_r[0], manual_reset_in_i};
    bus_request_in_sync_nxt = {bus_request_in_sync_r[0], bus_request_in_i};
  end

  // Synchronised levels, only second stage read
  assign manual_reset_in_act = ~manual_reset_in_sync_r[1];
  assign bus_request_in_act = ~bus_request_in_sync_r[1];

  // Mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    hiz_nxt  = hiz_r;
    addr_port_nxt = addr_port_r;
    unique case (mode_r)
      PSC_ST_RESET: begin
        mode_nxt = PSC_ST_NORMAL;
        addr_port_nxt = power_on_i;
      end
      PSC_ST_NORMAL: begin
        if (ctrl_i.standby_req) begin
          mode_nxt = PSC_ST_STANDBY;
          hiz_nxt  = ctrl_i.port_hiz;
        end else if (bus_request_in_act) begin
          mode_nxt = PSC_ST_RELEASE;
        end else if (ctrl_i.sleep_req) begin
          mode_nxt = PSC_ST_SLEEP;
        end
      end
      PSC_ST_SLEEP: if (ctrl_i.wake_req) mode_nxt = PSC_ST_NORMAL;
      PSC_ST_STANDBY: if (ctrl_i.wake_req) mode_nxt = PSC_ST_NORMAL;
      PSC_ST_RELEASE: begin
        if (ctrl_i.standby_req) begin
          mode_nxt = PSC_ST_REL_SBY;
          hiz_nxt  = ctrl_i.port_hiz;
        end else if (!bus_request_in_act) begin
          mode_nxt = PSC_ST_NORMAL;
        end
      end
      PSC_ST_REL_SBY: if (ctrl_i.wake_req) mode_nxt = PSC_ST_RELEASE;
      default: mode_nxt = PSC_ST_RESET;
    endcase
    if (manual_reset_in_act) mode_nxt = PSC_ST_RESET;
  end

  assign in_sby = (mode_r == PSC_ST_STANDBY) || (mode_r == PSC_ST_REL_SBY);
  assign in_rel = (mode_r == PSC_ST_RELEASE) || (mode_r == PSC_ST_REL_SBY);

  // Keep state capture and bus levels
  always_comb begin
    keep_val_nxt = keep_val_r;
    keep_dir_nxt = keep_dir_r;
    addr_nxt     = addr_r;
    busctl_nxt   = BUSCTL_IDLE;
    if (mode_r == PSC_ST_NORMAL) begin
      keep_val_nxt = port_out_i;
      keep_dir_nxt = port_dir_i;
      addr_nxt     = ctrl_i.addr;
      if (ctrl_i.onchip_acc) begin
        busctl_nxt.row_strobe_n = ~(ctrl_i.row_active | ctrl_i.refresh);
        busctl_nxt.col_strobe_n = {LANE_W{~ctrl_i.refresh}};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      manual_reset_in_sync_r <= 2'h3;
      bus_request_in_sync_r <= 2'h3;
      mode_r      <= PSC_ST_RESET;
      addr_port_r <= 1'b1;
      hiz_r       <= 1'b0;
      keep_val_r  <= '0;
      keep_dir_r  <= '0;
      addr_r      <= '0;
      busctl_r    <= BUSCTL_IDLE;
    end else if (clk_en_i) begin
      manual_reset_in_sync_r <= manual_reset_in_sync_nxt;
      bus_request_in_sync_r <= bus_request_in_sync_nxt;
      mode_r      <= mode_nxt;
      addr_port_r <= addr_port_nxt;
      hiz_r       <= hiz_nxt;
      keep_val_r  <= keep_val_nxt;
      keep_dir_r  <= keep_dir_nxt;
      addr_r      <= addr_nxt;
      busctl_r    <= busctl_nxt;
    end
  end

  // Pin enables per mode
  always_comb begin
    addr_oe_o = (in_sby || in_rel) ? '0 : '1;
    if (addr_port_r)
      addr_oe_o[ADDR_PORT_LO +: ADDR_PORT_W] = '0;
  end
  assign addr_o            = addr_r;
  assign data_oe_o         = 1'b0;
  assign busctl_o          = busctl_r;
  assign busctl_oe_o       = !(in_sby || in_rel);
  assign clock_output_o    = in_sby ? 1'b1 : clk_int_i;
  assign clock_output_oe_o = !(in_sby && hiz_r);
  assign bus_grant_n_o     = !in_rel;
  assign bus_grant_oe_o    = !(mode_r == PSC_ST_STANDBY);
  assign port_o            = (in_sby || mode_r == PSC_ST_SLEEP) ? keep_val_r : port_out_i;
  assign port_oe_o         = (in_sby && hiz_r) ? '0 :
                             (in_sby || mode_r == PSC_ST_SLEEP) ? keep_dir_r : port_dir_i;
  assign mode_o            = mode_r;

  property p_standby_first;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && mode_r == PSC_ST_NORMAL && ctrl_i.standby_req && !manual_reset_in_act)
        |=> mode_r == PSC_ST_STANDBY;
  endproperty
  a_standby_first: assert property (p_standby_first) else $error("standby lost");

  property p_hiz;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (in_sby && hiz_r) |-> (port_oe_o == '0 && !clock_output_oe_o);
  endproperty
  a_hiz: assert property (p_hiz) else $error("standby pins driven");

  property p_addr_port;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      addr_port_r |-> addr_oe_o[ADDR_PORT_LO +: ADDR_PORT_W] == '0;
  endproperty
  a_addr_port: assert property (p_addr_port) else $error("upper address driven");

  property p_keep;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (mode_r == PSC_ST_SLEEP) |-> (port_o == keep_val_r && port_oe_o == keep_dir_r);
  endproperty
  a_keep: assert property (p_keep) else $error("keep state broken");

  property p_row;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && mode_r == PSC_ST_NORMAL && ctrl_i.onchip_acc && !ctrl_i.row_active
       && !ctrl_i.refresh) |=> busctl_o.row_strobe_n;
  endproperty
  a_row: assert property (p_row) else $error("row strobe low");

  property p_col;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && !ctrl_i.refresh) |=> busctl_o.col_strobe_n == '1;
  endproperty
  a_col: assert property (p_col) else $error("column strobe low");

  property p_onchip;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      busctl_o.cs_n == '1 && busctl_o.rd_n && busctl_o.rd_wr && busctl_o.wr_strobe_n == '1
      && !busctl_o.address_hold_n && !data_oe_o;
  endproperty
  a_onchip: assert property (p_onchip) else $error("on-chip levels wrong");

  property p_release;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (mode_r == PSC_ST_RELEASE) |-> (!bus_grant_n_o && !busctl_oe_o && addr_oe_o == '0);
  endproperty
  a_release: assert property (p_release) else $error("release pins wrong");

  property p_standby;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      in_sby |-> (clock_output_o && !busctl_oe_o && addr_oe_o == '0);
  endproperty
  a_standby: assert property (p_standby) else $error("standby pins wrong");
endmodule
`default_nettype wire

// [pkg/psc_pkg.sv]
`default_nettype none
package psc_pkg;
  localparam int ADDR_W       = 22;   // Address bus width
  localparam int DATA_W       = 32;   // Data bus width
  localparam int CS_W         = 4;    // Chip select count
  localparam int LANE_W       = 4;    // Byte strobe count
  localparam int ADDR_PORT_LO = 18;   // First address line turned to port
  localparam int ADDR_PORT_W  = 4;    // Address lines turned to port
  localparam logic [2:0] MODE_RESET = 3'h0;

  typedef enum logic [2:0] {
    PSC_ST_RESET   = 3'b000,
    PSC_ST_NORMAL  = 3'b001,
    PSC_ST_SLEEP   = 3'b010,
    PSC_ST_STANDBY = 3'b011,
    PSC_ST_RELEASE = 3'b100,
    PSC_ST_REL_SBY = 3'b101
  } psc_mode_t;

  // Requests from the core side
  typedef struct packed {
    logic              standby_req;   // Enter software standby
    logic              sleep_req;     // Enter sleep
    logic              wake_req;      // Leave standby or sleep
    logic              port_hiz;      // Standby port high-impedance bit
    logic              onchip_acc;    // Access to on-chip ROM/RAM/peripheral
    logic              row_active;    // Row strobe down state
    logic              refresh;       // Refresh in progress
    logic [ADDR_W-1:0] addr;          // Address of the access
  } psc_ctrl_t;

  // Bus control pin levels
  typedef struct packed {
    logic [CS_W-1:0]   cs_n;          // Chip selects
    logic              row_strobe_n;  // Row strobe
    logic [LANE_W-1:0] col_strobe_n;  // Column strobes byte3..byte0
    logic              rd_wr;         // Read/write line
    logic              rd_n;          // Read strobe
    logic [LANE_W-1:0] wr_strobe_n;   // Write strobes byte3..byte0
    logic              address_hold_n;// Address hold
  } psc_busctl_t;
endpackage
`default_nettype wire

// [test/psc_bus_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
// External master: asks for the bus, drives address only while granted
module psc_bus_master_model
  import psc_pkg::*;
(
  input  wire logic              sys_clk_i,        // System clock
  input  wire logic              want_bus_i,       // Bench asks for the bus
  input  wire logic              bus_grant_n_i,    // Grant from device
  output logic                   bus_request_in_o, // Request pin, active low
  output logic [ADDR_W-1:0]      ext_addr_o,       // Address driven when granted
  output logic                   ext_addr_oe_o     // Master drives address
);
  initial bus_request_in_o = 1'b1;
  initial ext_addr_o = 22'h15A5A5;
  initial ext_addr_oe_o = 1'b0;
  // Request, then take the lines only after grant; pattern moves when idle
  always @(posedge sys_clk_i) begin
    bus_request_in_o <= ~want_bus_i;
    ext_addr_oe_o    <= want_bus_i & ~bus_grant_n_i;
    ext_addr_o       <= ext_addr_oe_o ? ext_addr_o : ~ext_addr_o;
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import psc_pkg::*;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, want_bus = 1'b0, req_n, grant_n, ext_oe;
  logic clk_en = 1'b1, power_on = 1'b1, manual_reset_in_n = 1'b1;
  psc_ctrl_t ctrl = '0;
  logic [DATA_W-1:0] pout = 32'h0000_A5C3, pdir = 32'h0000_FFFF, port_o, port_oe;
  logic [ADDR_W-1:0] addr, addr_oe, ext_addr, bus_addr;
  logic ck, ck_oe, gnt_oe, data_oe, bc_oe;
  psc_busctl_t bc;
  psc_mode_t mode;
  int errors = 0, compares = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  // Address wire as seen by both parties
  assign bus_addr = (addr_oe & addr) | (~addr_oe & (ext_oe ? ext_addr : ~ext_addr));
  psc_pin_state u_psc_pin_state (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en),
    .power_on_i(power_on), .manual_reset_in_i(manual_reset_in_n), .bus_request_in_i(req_n), .ctrl_i(ctrl),
    .clk_int_i(1'b0), .port_out_i(pout), .port_dir_i(pdir), .port_o(port_o),
    .port_oe_o(port_oe), .clock_output_o(ck), .clock_output_oe_o(ck_oe),
    .bus_grant_n_o(grant_n), .bus_grant_oe_o(gnt_oe), .addr_o(addr), .addr_oe_o(addr_oe),
    .data_oe_o(data_oe), .busctl_o(bc), .busctl_oe_o(bc_oe), .mode_o(mode));
  psc_bus_master_model u_psc_bus_master_model (.sys_clk_i(sys_clk_i), .want_bus_i(want_bus),
    .bus_grant_n_i(grant_n), .bus_request_in_o(req_n), .ext_addr_o(ext_addr),
    .ext_addr_oe_o(ext_oe));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset state and upper address lines as ports
  task automatic t_reset;
    chk("mode", PSC_ST_NORMAL, mode);
    chk("addr_oe_top", 4'h0, addr_oe[ADDR_PORT_LO +: ADDR_PORT_W]);
    chk("addr_oe_low", 18'h3FFFF, addr_oe[ADDR_PORT_LO-1:0]);
    $display("test reset done");
  endtask
  // On-chip access with plain, row-active and refresh cycles
  task automatic t_onchip;
    @(posedge sys_clk_i);
    ctrl.onchip_acc <= 1'b1;
    ctrl.addr <= 22'h2C3A5F;
    cyc(2);
    chk("cs_rd_wr", {4'hF, 1'b1, 4'hF, 1'b1, 1'b1, 4'hF, 1'b0}, bc);
    chk("addr", 22'h2C3A5F & 22'h03FFFF, addr & 22'h03FFFF);
    chk("addr_oe", 22'h03FFFF, addr_oe);
    chk("data_oe", 1'b0, data_oe);
    @(posedge sys_clk_i);
    ctrl.row_active <= 1'b1;
    cyc(2);
    chk("row_col", 5'h0F, {bc.row_strobe_n, bc.col_strobe_n});
    @(posedge sys_clk_i);
    ctrl.row_active <= 1'b0;
    ctrl.refresh <= 1'b1;
    cyc(2);
    chk("row_col_ref", 5'h00, {bc.row_strobe_n, bc.col_strobe_n});
    @(posedge sys_clk_i);
    ctrl.refresh <= 1'b0;
    ctrl.onchip_acc <= 1'b0;
    cyc(2);
    chk("row_col_idle", 5'h1F, {bc.row_strobe_n, bc.col_strobe_n});
    $display("test onchip done");
  endtask
  // Standby with and without the port float bit, keep state
  task automatic t_standby(input logic hiz);
    @(posedge sys_clk_i);
    ctrl.port_hiz <= hiz;
    ctrl.standby_req <= 1'b1;
    cyc(1);
    chk("mode_sby", PSC_ST_STANDBY, mode);
    @(posedge sys_clk_i);
    pout <= 32'h0000_3C5A;
    cyc(2);
    chk("floats", 2'b00, {|addr_oe, bc_oe});
    chk("grant_oe", 1'b0, gnt_oe);
    chk("port_oe", hiz ? 32'h0 : pdir, port_oe);
    if (!hiz) chk("port_keep", 16'hA5C3, port_o[15:0]);
    chk("ck", hiz ? 2'b00 : 2'b11, {ck_oe, ck & ck_oe});
    @(posedge sys_clk_i);
    ctrl.standby_req <= 1'b0;
    ctrl.wake_req <= 1'b1;
    @(posedge sys_clk_i);
    ctrl.wake_req <= 1'b0;
    pout <= 32'h0000_A5C3;
    cyc(1);
    chk("mode_wake", PSC_ST_NORMAL, mode);
    $display("test standby done");
  endtask
  // Sleep asked while the clock enable is low, then keep state in sleep
  task automatic t_sleep;
    @(posedge sys_clk_i);
    clk_en <= 1'b0;
    ctrl.sleep_req <= 1'b1;
    cyc(3);
    chk("mode_frozen", PSC_ST_NORMAL, mode);
    @(posedge sys_clk_i);
    clk_en <= 1'b1;
    cyc(1);
    chk("mode_sleep", PSC_ST_SLEEP, mode);
    @(posedge sys_clk_i);
    ctrl.sleep_req <= 1'b0;
    pout <= 32'h0000_3C5A;
    pdir <= 32'h0000_00FF;
    cyc(2);
    chk("sleep_keep", {32'h0000_A5C3, 32'h0000_FFFF}, {port_o, port_oe});
    @(posedge sys_clk_i);
    ctrl.wake_req <= 1'b1;
    pout <= 32'h0000_A5C3;
    pdir <= 32'h0000_FFFF;
    @(posedge sys_clk_i);
    ctrl.wake_req <= 1'b0;
    cyc(1);
    chk("sleep_wake", PSC_ST_NORMAL, mode);
    $display("test sleep done");
  endtask
  // Bus released to the external master, standby while released
  task automatic t_release;
    @(posedge sys_clk_i);
    want_bus <= 1'b1;
    cyc(6);
    chk("grant", 5'h10, {gnt_oe, grant_n, |addr_oe, bc_oe, data_oe});
    chk("bus_addr", ext_addr, bus_addr);
    @(posedge sys_clk_i);
    ctrl.standby_req <= 1'b1;
    cyc(1);
    chk("rel_sby", {1'b0, 1'b1, PSC_ST_REL_SBY}, {grant_n, gnt_oe, mode});
    @(posedge sys_clk_i);
    ctrl.standby_req <= 1'b0;
    ctrl.wake_req <= 1'b1;
    @(posedge sys_clk_i);
    ctrl.wake_req <= 1'b0;
    cyc(1);
    chk("rel_back", {1'b0, PSC_ST_RELEASE}, {grant_n, mode});
    @(posedge sys_clk_i);
    want_bus <= 1'b0;
    cyc(6);
    chk("grant_off", {1'b1, PSC_ST_NORMAL}, {grant_n, mode});
    $display("test release done");
  endtask
  // Synchronised request and standby reach the mode logic at the same edge
  task automatic t_race;
    @(posedge sys_clk_i);
    want_bus <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ctrl.standby_req <= 1'b1;
    cyc(1);
    chk("not_release", PSC_ST_STANDBY, mode);
    @(posedge sys_clk_i);
    ctrl.standby_req <= 1'b0;
    want_bus <= 1'b0;
    ctrl.wake_req <= 1'b1;
    @(posedge sys_clk_i);
    ctrl.wake_req <= 1'b0;
    cyc(6);
    chk("race_end", PSC_ST_NORMAL, mode);
    $display("test race done");
  endtask
  // Manual reset without power-on, then a mid-run power-on reset
  task automatic t_manual;
    @(posedge sys_clk_i);
    power_on <= 1'b0;
    manual_reset_in_n <= 1'b0;
    cyc(3);
    chk("manual_reset_in_mode", PSC_ST_RESET, mode);
    @(posedge sys_clk_i);
    manual_reset_in_n <= 1'b1;
    cyc(4);
    chk("manual_reset_in_addr", {PSC_ST_NORMAL, 22'h3FFFFF}, {mode, addr_oe});
    @(posedge sys_clk_i);
    power_on <= 1'b1;
    resetn_i <= 1'b0;
    cyc(1);
    chk("rst_hold", {PSC_ST_RESET, 4'h0}, {mode, addr_oe[ADDR_PORT_LO +: ADDR_PORT_W]});
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    cyc(2);
    chk("rst_addr", {PSC_ST_NORMAL, 22'h03FFFF}, {mode, addr_oe});
    $display("test manual done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    cyc(3);
    t_reset();
    t_onchip();
    t_standby(1'b0);
    t_standby(1'b1);
    t_sleep();
    t_release();
    t_race();
    t_manual();
    finish_test();
  end
  // Watchdog, far beyond the roughly 93 cycles the tests take
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
